// File: include/ttcu_regs.vh
// addresses, fields and reset values of the timer/counter unit
// assumes 8-bit register addresses and data
`ifndef TTCU_REGS_VH
`define TTCU_REGS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define TTCU_ADDR_T01_CONTROL 8'h88
`define TTCU_ADDR_T01_MODE 8'h89
`define TTCU_ADDR_T0_LOW 8'h8A
`define TTCU_ADDR_T1_LOW 8'h8B
`define TTCU_ADDR_T0_HIGH 8'h8C
`define TTCU_ADDR_T1_HIGH 8'h8D
`define TTCU_ADDR_T2_CONTROL 8'hC8
`define TTCU_ADDR_T2_RELOAD_LOW 8'hCA
`define TTCU_ADDR_T2_RELOAD_HIGH 8'hCB
`define TTCU_ADDR_T2_LOW 8'hCC
`define TTCU_ADDR_T2_HIGH 8'hCD

// ----------------------------------------------------------------
// bit-addressable blocks: bit address [7:3]
// ----------------------------------------------------------------
`define TTCU_BITBASE_T01_CONTROL 5'h11
`define TTCU_BITBASE_T2_CONTROL 5'h19

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define TTCU_CTL_UNIT1_OVF 7
`define TTCU_CTL_UNIT1_RUN 6
`define TTCU_CTL_UNIT0_OVF 5
`define TTCU_CTL_UNIT0_RUN 4

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define TTCU_MOD_UNIT1_GATE 7
`define TTCU_MOD_UNIT1_SRC 6
`define TTCU_MOD_UNIT1_MODE_HI 5
`define TTCU_MOD_UNIT1_MODE_LO 4
`define TTCU_MOD_UNIT0_GATE 3
`define TTCU_MOD_UNIT0_SRC 2
`define TTCU_MOD_UNIT0_MODE_HI 1
`define TTCU_MOD_UNIT0_MODE_LO 0

// ----------------------------------------------------------------
// mode encodings
// ----------------------------------------------------------------
`define TTCU_MODE_PRESCALE 2'h0
`define TTCU_MODE_CASCADE 2'h1
`define TTCU_MODE_RELOAD 2'h2
`define TTCU_MODE_SPLIT 2'h3
`define TTCU_PRESCALE_TOP 5'h1F
`define TTCU_BYTE_TOP 8'hFF

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TTCU_RST_BYTE 8'h00

`endif

// File: rtl/ttcu_fall_detect.v
// falling-edge detector for one external event input
// assumes the pin is synchronous to clk
module ttcu_fall_detect (
    input wire clk,
    input wire reset,
    input wire pin,
    output reg fall
);

    reg sample_now; // sample of this cycle
    reg sample_prev; // sample of the previous cycle

    // ------------------------------------------------------------
    // sampling: high in one sample, low in the next gives a pulse
    // ------------------------------------------------------------
    // the pulse is registered too, costing one cycle of latency;
    // the rate limit stays at half the clock
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sample_now <= 1'b0;
            sample_prev <= 1'b0;
            fall <= 1'b0;
        end else begin
            sample_now <= pin;
            sample_prev <= sample_now;
            fall <= sample_prev & ~sample_now;
        end
    end

endmodule

// File: rtl/ttcu_timer_unit.v
// timer/counter unit: units 0 and 1 count, unit 2 only stores
// assumes a core register port with one-cycle strobes and bit-set access
//
// Operation
// - three 16-bit units, high and low bytes
// - timer mode advances low byte every cycle
// - counter mode counts sampled falling pin edges
// - control at 0x88 bit-addressable, mode at 0x89
// - low bytes 0x8A/0x8B, high bytes 0x8C/0x8D
// - unit 2 control 0xC8, counts 0xCC/0xCD
// - unit 2 reload value at 0xCA/0xCB
// - mode bit 7 gates unit 1 by pin
// - mode bit 6 picks unit 1 source
// - mode bits 5:4 select unit 1 mode
// - mode 00: 5-bit prescaler plus 8-bit count
// - mode 01: full 16-bit cascade
// - mode 10: low byte reloads from high byte
// - mode 11 halts unit 1
// - bits 3:0 mirror fields for unit 0
// - unit 0 mode 11 splits into two counters
// - overflow flag set by hardware, cleared on vector
// - unit 1 run bit starts and stops it
`include "ttcu_regs.vh"

module ttcu_timer_unit (
    input wire clk,
    input wire reset,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    input wire sfr_bit_wr,
    input wire [7:0] sfr_bit_addr,
    input wire sfr_bit_wdata,
    input wire unit0_event_pin,
    input wire unit1_event_pin,
    input wire ext_interrupt_zero_pin,
    input wire ext_interrupt_one_pin,
    input wire unit0_vector_ack,
    input wire unit1_vector_ack,
    output wire unit0_overflow_flag,
    output wire unit1_overflow_flag
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    reg [7:0] timer01_control; // flags, run bits, external interrupt bits
    reg [7:0] timer01_mode; // gating, source and mode of units 0 and 1
    reg [7:0] timer0_low_byte;
    reg [7:0] timer0_high_byte;
    reg [7:0] timer1_low_byte;
    reg [7:0] timer1_high_byte;
    reg [7:0] timer2_control; // stored only
    reg [7:0] timer2_reload_low;
    reg [7:0] timer2_reload_high;
    reg [7:0] timer2_low_byte;
    reg [7:0] timer2_high_byte;

    wire [1:0] event_fall; // falling-edge pulses of the event pins
    wire [1:0] event_pins; // pins in unit order

    // ------------------------------------------------------------
    // falling-edge samplers, one per event pin
    // ------------------------------------------------------------
    assign event_pins = {unit1_event_pin, unit0_event_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_fall
            ttcu_fall_detect u_fall (
                .clk(clk),
                .reset(reset),
                .pin(event_pins[gi]),
                .fall(event_fall[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // count step for one unit in modes 00, 01 and 10
    // ------------------------------------------------------------
    // result is {overflow, high, low}; no tick, no change
    function [16:0] count_step;
        input [1:0] mode;
        input [7:0] high;
        input [7:0] low;
        input tick;
        begin
            count_step = {1'b0, high, low};
            if (tick) begin
                case (mode)
                    `TTCU_MODE_PRESCALE: begin
                        // low-byte bits 7:5 stay as they are
                        if (low[4:0] == `TTCU_PRESCALE_TOP) begin
                            count_step = {(high == `TTCU_BYTE_TOP), high + 8'h01,
                                          low[7:5], 5'h00};
                        end else begin
                            count_step = {1'b0, high, low[7:5], low[4:0] + 5'h01};
                        end
                    end
                    `TTCU_MODE_CASCADE: begin
                        count_step = {1'b0, high, low} + 17'h0_0001;
                    end
                    `TTCU_MODE_RELOAD: begin
                        if (low == `TTCU_BYTE_TOP) begin
                            count_step = {1'b1, high, high};
                        end else begin
                            count_step = {1'b0, high, low + 8'h01};
                        end
                    end
                    default: begin
                        count_step = {1'b0, high, low};
                    end
                endcase
            end
        end
    endfunction

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    wire [1:0] unit0_mode;
    wire [1:0] unit1_mode;
    wire unit0_run;
    wire unit1_run;
    wire unit0_enable;
    wire unit1_enable;
    wire unit0_tick;
    wire unit1_tick;
    wire unit0_split;

    assign unit0_mode = {timer01_mode[`TTCU_MOD_UNIT0_MODE_HI],
                         timer01_mode[`TTCU_MOD_UNIT0_MODE_LO]};
    assign unit1_mode = {timer01_mode[`TTCU_MOD_UNIT1_MODE_HI],
                         timer01_mode[`TTCU_MOD_UNIT1_MODE_LO]};
    assign unit0_run = timer01_control[`TTCU_CTL_UNIT0_RUN];
    assign unit1_run = timer01_control[`TTCU_CTL_UNIT1_RUN];
    assign unit0_split = (unit0_mode == `TTCU_MODE_SPLIT);

    // gating: run bit alone, or run bit and interrupt pin high
    assign unit0_enable = unit0_run &
        (~timer01_mode[`TTCU_MOD_UNIT0_GATE] | ext_interrupt_zero_pin);
    assign unit1_enable = unit1_run &
        (~timer01_mode[`TTCU_MOD_UNIT1_GATE] | ext_interrupt_one_pin);

    // source: every machine cycle, or a sampled falling edge
    assign unit0_tick = unit0_enable &
        (timer01_mode[`TTCU_MOD_UNIT0_SRC] ? event_fall[0] : 1'b1);
    assign unit1_tick = unit1_enable &
        (timer01_mode[`TTCU_MOD_UNIT1_SRC] ? event_fall[1] : 1'b1);

    // ------------------------------------------------------------
    // next count values
    // ------------------------------------------------------------
    reg [7:0] next_t0_low;
    reg [7:0] next_t0_high;
    reg [7:0] next_t1_low;
    reg [7:0] next_t1_high;
    reg unit0_wrap; // sets unit 0 flag
    reg unit1_wrap; // sets unit 1 flag
    reg [16:0] step0;
    reg [16:0] step1;

    always @* begin
        step0 = count_step(unit0_mode, timer0_high_byte, timer0_low_byte, unit0_tick);
        step1 = count_step(unit1_mode, timer1_high_byte, timer1_low_byte, unit1_tick);
        next_t0_low = step0[7:0];
        next_t0_high = step0[15:8];
        unit0_wrap = step0[16];
        next_t1_low = step1[7:0];
        next_t1_high = step1[15:8];
        // unit 1 still counts while unit 0 is split, but its flag then
        // belongs to the unit 0 high byte, so its own wrap is dropped
        unit1_wrap = step1[16] & ~unit0_split;
        if (unit0_split) begin
            // low byte: 8-bit count under unit 0 controls
            unit0_wrap = unit0_tick & (timer0_low_byte == `TTCU_BYTE_TOP);
            next_t0_low = timer0_low_byte + {7'h00, unit0_tick};
            // high byte: machine-cycle timer run by the unit 1 run bit
            next_t0_high = timer0_high_byte + {7'h00, unit1_run};
            unit1_wrap = unit1_run & (timer0_high_byte == `TTCU_BYTE_TOP);
        end
    end

    // ------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------
    wire wr_control;
    wire wr_mode;
    wire bit_control;
    wire bit_t2_control;
    reg [7:0] bit_mask; // one-hot lane of a bit access

    assign wr_control = sfr_wr & (sfr_addr == `TTCU_ADDR_T01_CONTROL);
    assign wr_mode = sfr_wr & (sfr_addr == `TTCU_ADDR_T01_MODE);
    assign bit_control = sfr_bit_wr &
        (sfr_bit_addr[7:3] == `TTCU_BITBASE_T01_CONTROL);
    assign bit_t2_control = sfr_bit_wr &
        (sfr_bit_addr[7:3] == `TTCU_BITBASE_T2_CONTROL);

    always @* begin
        bit_mask = 8'h01 << sfr_bit_addr[2:0];
    end

    // byte write, or a bit write merged into the old value
    function [7:0] merge;
        input [7:0] old;
        input byte_wr;
        input [7:0] byte_data;
        input bit_wr;
        input [7:0] mask;
        input bit_data;
        begin
            merge = old;
            if (byte_wr) begin
                merge = byte_data;
            end else if (bit_wr) begin
                merge = bit_data ? (old | mask) : (old & ~mask);
            end
        end
    endfunction

    // ------------------------------------------------------------
    // control register with hardware-set overflow flags
    // ------------------------------------------------------------
    // the flag set wins over a software clear or a vector acknowledge in
    // the same cycle, so no overflow is lost to a clear or acknowledge
    reg [7:0] next_control;

    always @* begin
        next_control = merge(timer01_control, wr_control, sfr_wdata,
                             bit_control, bit_mask, sfr_bit_wdata);
        if (unit0_vector_ack) begin
            next_control[`TTCU_CTL_UNIT0_OVF] = 1'b0;
        end
        if (unit1_vector_ack) begin
            next_control[`TTCU_CTL_UNIT1_OVF] = 1'b0;
        end
        if (unit0_wrap) begin
            next_control[`TTCU_CTL_UNIT0_OVF] = 1'b1;
        end
        if (unit1_wrap) begin
            next_control[`TTCU_CTL_UNIT1_OVF] = 1'b1;
        end
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            timer01_control <= `TTCU_RST_BYTE;
            timer01_mode <= `TTCU_RST_BYTE;
        end else begin
            timer01_control <= next_control;
            if (wr_mode) begin
                timer01_mode <= sfr_wdata; // byte access only
            end
        end
    end

    // ------------------------------------------------------------
    // count bytes of units 0 and 1
    // ------------------------------------------------------------
    // a software write to a byte beats its count step
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            timer0_low_byte <= `TTCU_RST_BYTE;
            timer0_high_byte <= `TTCU_RST_BYTE;
            timer1_low_byte <= `TTCU_RST_BYTE;
            timer1_high_byte <= `TTCU_RST_BYTE;
        end else begin
            if (sfr_wr && sfr_addr == `TTCU_ADDR_T0_LOW) begin
                timer0_low_byte <= sfr_wdata;
            end else begin
                timer0_low_byte <= next_t0_low;
            end
            if (sfr_wr && sfr_addr == `TTCU_ADDR_T0_HIGH) begin
                timer0_high_byte <= sfr_wdata;
            end else begin
                timer0_high_byte <= next_t0_high;
            end
            if (sfr_wr && sfr_addr == `TTCU_ADDR_T1_LOW) begin
                timer1_low_byte <= sfr_wdata;
            end else begin
                timer1_low_byte <= next_t1_low;
            end
            if (sfr_wr && sfr_addr == `TTCU_ADDR_T1_HIGH) begin
                timer1_high_byte <= sfr_wdata;
            end else begin
                timer1_high_byte <= next_t1_high;
            end
        end
    end

    // ------------------------------------------------------------
    // unit 2 registers
    // ------------------------------------------------------------
    // unit 2 counting, capture and reload are not built; its registers
    // hold what software writes
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            timer2_control <= `TTCU_RST_BYTE;
            timer2_reload_low <= `TTCU_RST_BYTE;
            timer2_reload_high <= `TTCU_RST_BYTE;
            timer2_low_byte <= `TTCU_RST_BYTE;
            timer2_high_byte <= `TTCU_RST_BYTE;
        end else begin
            timer2_control <= merge(timer2_control,
                                    sfr_wr && sfr_addr == `TTCU_ADDR_T2_CONTROL,
                                    sfr_wdata, bit_t2_control, bit_mask,
                                    sfr_bit_wdata);
            if (sfr_wr && sfr_addr == `TTCU_ADDR_T2_RELOAD_LOW) begin
                timer2_reload_low <= sfr_wdata;
            end
            if (sfr_wr && sfr_addr == `TTCU_ADDR_T2_RELOAD_HIGH) begin
                timer2_reload_high <= sfr_wdata;
            end
            if (sfr_wr && sfr_addr == `TTCU_ADDR_T2_LOW) begin
                timer2_low_byte <= sfr_wdata;
            end
            if (sfr_wr && sfr_addr == `TTCU_ADDR_T2_HIGH) begin
                timer2_high_byte <= sfr_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // registered: data appears the cycle after the read strobe; other
    // addresses read zero so the core may mux many blocks by OR
    reg [7:0] read_mux;

    always @* begin
        case (sfr_addr)
            `TTCU_ADDR_T01_CONTROL: read_mux = timer01_control;
            `TTCU_ADDR_T01_MODE: read_mux = timer01_mode;
            `TTCU_ADDR_T0_LOW: read_mux = timer0_low_byte;
            `TTCU_ADDR_T1_LOW: read_mux = timer1_low_byte;
            `TTCU_ADDR_T0_HIGH: read_mux = timer0_high_byte;
            `TTCU_ADDR_T1_HIGH: read_mux = timer1_high_byte;
            `TTCU_ADDR_T2_CONTROL: read_mux = timer2_control;
            `TTCU_ADDR_T2_RELOAD_LOW: read_mux = timer2_reload_low;
            `TTCU_ADDR_T2_RELOAD_HIGH: read_mux = timer2_reload_high;
            `TTCU_ADDR_T2_LOW: read_mux = timer2_low_byte;
            `TTCU_ADDR_T2_HIGH: read_mux = timer2_high_byte;
            default: read_mux = 8'h00;
        endcase
    end

    always @(posedge clk or posedge reset) begin
        if (reset) begin
            sfr_rdata <= `TTCU_RST_BYTE;
        end else if (sfr_rd) begin
            sfr_rdata <= read_mux;
        end
    end

    // ------------------------------------------------------------
    // flag outputs toward the interrupt controller
    // ------------------------------------------------------------
    assign unit0_overflow_flag = timer01_control[`TTCU_CTL_UNIT0_OVF];
    assign unit1_overflow_flag = timer01_control[`TTCU_CTL_UNIT1_OVF];

endmodule

// File: sim/ttcu_pin_model.sv
// far-side pins: event sources and gate levels
// assumes start is a one-cycle pulse and hold is never zero
module ttcu_pin_model (
    input wire clk,
    input wire start,
    input wire [7:0] n_fall,
    input wire [1:0] hold,
    input wire gate0,
    input wire unit1_gating,
    output wire ext_interrupt_zero_pin,
    output wire ext_interrupt_one_pin,
    output logic unit0_event_pin = 1'b1,
    output logic unit1_event_pin = 1'b1,
    output logic busy = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // gate sources are slow levels, passed straight through
    assign ext_interrupt_zero_pin = gate0;
    assign ext_interrupt_one_pin = unit1_gating;
    // burst of falls, each level held hold cycles; 1 is max rate
    always @(posedge clk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            for (int i = 0; i < n_fall; i++) begin
                repeat (hold) @(posedge clk);
                {unit0_event_pin, unit1_event_pin} <= 2'b00;
                repeat (hold) @(posedge clk);
                {unit0_event_pin, unit1_event_pin} <= 2'b11;
            end
            busy <= 1'b0;
        end
    end
endmodule

// File: sim/ttcu_timer_unit_checker.sv
// checker of the register port and overflow flags
// bound onto ttcu_timer_unit; sees only its ports
module ttcu_timer_unit_checker (
    input wire clk,
    input wire reset,
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire sfr_rd,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata,
    input wire sfr_bit_wr,
    input wire [7:0] sfr_bit_addr,
    input wire sfr_bit_wdata,
    input wire unit0_vector_ack,
    input wire unit1_vector_ack,
    input wire unit0_overflow_flag,
    input wire unit1_overflow_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    // decoded byte addresses; everything else must read zero
    wire mapped = (sfr_addr >= 8'h88 && sfr_addr <= 8'h8D) || sfr_addr == 8'hC8 ||
        (sfr_addr >= 8'hCA && sfr_addr <= 8'hCD);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // plain storage: a read right after a write returns it
    property p_store(a);
        sfr_wr && sfr_addr == a ##1 sfr_rd && !sfr_wr && sfr_addr == a
            |=> sfr_rdata == $past(sfr_wdata, 2);
    endproperty
    AST_MODE_RW: assert property (p_store(8'h89))
        else $error("mode readback");
    AST_RELOAD_LOW_RW: assert property (p_store(8'hCA))
        else $error("reload low readback");
    AST_RELOAD_HIGH_RW: assert property (p_store(8'hCB))
        else $error("reload high readback");
    AST_UNMAPPED_ZERO: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00)
        else $error("unmapped read");
    AST_RDATA_HOLDS: assert property (!sfr_rd |=> $stable(sfr_rdata))
        else $error("read data moved");
    AST_CTL_READ_FLAGS: assert property (sfr_rd && sfr_addr == 8'h88 |=>
        sfr_rdata[7] == $past(unit1_overflow_flag) && sfr_rdata[5] == $past(unit0_overflow_flag))
        else $error("control read");
    AST_SW_SET_FLAG1: assert property (sfr_wr && sfr_addr == 8'h88 && sfr_wdata[7] &&
        !unit1_vector_ack |=> unit1_overflow_flag) else $error("flag1 byte set");
    AST_BIT_SET_FLAG0: assert property (sfr_bit_wr && !sfr_wr && sfr_bit_addr == 8'h8D &&
        sfr_bit_wdata && !unit0_vector_ack |=> unit0_overflow_flag)
        else $error("flag0 bit set");
    AST_FLAG1_CLEAR_CAUSE: assert property ($fell(unit1_overflow_flag) |->
        $past(unit1_vector_ack) || $past(sfr_wr) || $past(sfr_bit_wr))
        else $error("flag1 clear");
    AST_FLAG0_CLEAR_CAUSE: assert property ($fell(unit0_overflow_flag) |->
        $past(unit0_vector_ack) || $past(sfr_wr) || $past(sfr_bit_wr))
        else $error("flag0 clear");
    AST_RESET_CLEARS: assert property ($fell(reset) |-> !unit0_overflow_flag &&
        !unit1_overflow_flag && sfr_rdata == 8'h00) else $error("reset state");
    // main scenarios reached
    cover property ($rose(unit0_overflow_flag));
    cover property ($rose(unit1_overflow_flag));
    cover property (sfr_bit_wr && sfr_bit_addr[7:3] == 5'h19);
endmodule

// File: sim/ttcu_timer_unit_tb.sv
// self-checking bench: register tasks, read monitor, timer scenarios
// assumes the pin model drives the pins; inputs move at negedge
`include "ttcu_regs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module ttcu_timer_unit_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_bit_addr = 8'h00, n_fall = 8'h00;
    logic sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_wdata = 1'b0;
    logic ack0 = 1'b0, ack1 = 1'b0, start = 1'b0, gate0 = 1'b0, unit1_gating = 1'b0;
    logic [1:0] hold = 2'h1, f;
    wire [7:0] sfr_rdata;
    wire ev0, ev1, gp0, gp1, busy, flag0, flag1;
    int num_errors = 0, tests_run = 0, n, total;
    logic [7:0] exp_q[$];
    logic [7:0] d, e;
    // 200 MHz core clock
    always #2.5 clk = ~clk;
    ttcu_timer_unit dut (.clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .sfr_bit_wr, .sfr_bit_addr, .sfr_bit_wdata, .unit0_event_pin(ev0),
        .unit1_event_pin(ev1), .ext_interrupt_zero_pin(gp0), .ext_interrupt_one_pin(gp1),
        .unit0_vector_ack(ack0), .unit1_vector_ack(ack1), .unit0_overflow_flag(flag0),
        .unit1_overflow_flag(flag1));
    ttcu_pin_model pins (.clk, .start, .n_fall, .hold, .gate0, .unit1_gating,
        .ext_interrupt_zero_pin(gp0), .ext_interrupt_one_pin(gp1), .unit0_event_pin(ev0),
        .unit1_event_pin(ev1), .busy);
    // ----------------------------------------------------------------
    // bus tasks; each starts and ends on a falling edge
    // ----------------------------------------------------------------
    task automatic wr(input [7:0] a, input [7:0] v);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        @(posedge clk) sfr_wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic bw(input [7:0] a, input v);
        sfr_bit_addr = a;
        sfr_bit_wdata = v;
        sfr_bit_wr = 1'b1;
        @(posedge clk) sfr_bit_wr <= 1'b0;
        @(negedge clk);
    endtask
    // expected byte queued for the monitor
    task automatic rd(input [7:0] a, input [7:0] v);
        exp_q.push_back(v);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clk) sfr_rd <= 1'b0;
        @(negedge clk);
    endtask
    // mode and count bytes of units 0, 1
    task automatic ld(input [7:0] m, input [7:0] l0, input [7:0] h0, input [7:0] l1,
        input [7:0] h1);
        wr(`TTCU_ADDR_T01_MODE, m);
        wr(`TTCU_ADDR_T0_LOW, l0);
        wr(`TTCU_ADDR_T0_HIGH, h0);
        wr(`TTCU_ADDR_T1_LOW, l1);
        wr(`TTCU_ADDR_T1_HIGH, h1);
    endtask
    // exactly c counting edges; flags sampled after c-1 of them
    task automatic run(input [7:0] on, input int c, output [1:0] fl);
        wr(`TTCU_ADDR_T01_CONTROL, on);
        repeat (c - 1) @(negedge clk);
        fl = {flag1, flag0};
        wr(`TTCU_ADDR_T01_CONTROL, 8'h00);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // monitor: read data checked at the negedge after the take
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (sfr_rd === 1'b1) begin
            @(negedge clk) e = exp_q.pop_front();
            `CHK(sfr_rdata, e)
        end
    end
    // watchdog, well past the test length
    initial begin
        #100_000;
        num_errors++;
        test_done();
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(24));
        repeat (12) @(negedge clk);
        reset = 1'b0;
        for (int a = 8'h88; a <= 8'hCD; a++) rd(a[7:0], 8'h00);
        $display("reset values done");
        for (int a = 8'h89; a <= 8'hCD; a++) begin
            d = $urandom;
            wr(a[7:0], d);
            rd(a[7:0], (a <= 8'h8D || a == 8'hC8 || a >= 8'hCA) ? d : 8'h00);
        end
        wr(`TTCU_ADDR_T2_CONTROL, 8'h00);
        bw(8'hCA, 1'b1);
        rd(`TTCU_ADDR_T2_CONTROL, 8'h04);
        $display("storage done");
        ld(8'h01, 8'hFE, 8'hFF, 8'h00, 8'h00);
        run(8'h10, 3, f);
        `CHK(f, 2'b01)
        rd(`TTCU_ADDR_T0_LOW, 8'h01);
        rd(`TTCU_ADDR_T0_HIGH, 8'h00);
        ld(8'h00, 8'h00, 8'h00, 8'hFE, 8'h05);
        run(8'h40, 3, f);
        rd(`TTCU_ADDR_T1_LOW, 8'hE1);
        rd(`TTCU_ADDR_T1_HIGH, 8'h06);
        ld(8'h20, 8'h00, 8'h00, 8'hFE, 8'h80);
        run(8'h40, 4, f);
        `CHK(f, 2'b10)
        rd(`TTCU_ADDR_T1_LOW, 8'h82);
        rd(`TTCU_ADDR_T1_HIGH, 8'h80);
        $display("timer modes done");
        wr(`TTCU_ADDR_T01_CONTROL, 8'h80);
        bw(8'h8D, 1'b1);
        {ack1, ack0} = 2'b10;
        @(negedge clk);
        {ack1, ack0} = 2'b01;
        `CHK({flag1, flag0}, 2'b01)
        @(negedge clk);
        ack0 = 1'b0;
        `CHK(flag0, 1'b0)
        $display("vector clear done");
        n = 5 + $urandom % 16;
        ld(8'h30, 8'h00, 8'h00, 8'h12, 8'h34);
        run(8'h40, n, f);
        `CHK(f, 2'b00)
        rd(`TTCU_ADDR_T1_LOW, 8'h12);
        rd(`TTCU_ADDR_T1_HIGH, 8'h34);
        $display("halt done");
        ld(8'h55, 8'h00, 8'h00, 8'h00, 8'h00);
        wr(`TTCU_ADDR_T01_CONTROL, 8'h50);
        total = 0;
        for (int p = 0; p < 2; p++) begin
            n_fall = 1 + $urandom % 20;
            hold = (p == 0) ? 2'h1 : 2'(1 + $urandom % 3);
            total += n_fall;
            start = 1'b1;
            @(negedge clk);
            start = 1'b0;
            wait (!busy);
            repeat (4) @(negedge clk);
        end
        wr(`TTCU_ADDR_T01_CONTROL, 8'h00);
        rd(`TTCU_ADDR_T0_LOW, total[7:0]);
        rd(`TTCU_ADDR_T1_LOW, total[7:0]);
        $display("event count done");
        ld(8'h99, 8'h00, 8'h00, 8'h00, 8'h00);
        for (int p = 0; p < 2; p++) begin
            gate0 = (p == 0);
            unit1_gating = (p == 1);
            @(negedge clk);
            run(8'h50, 6, f);
        end
        rd(`TTCU_ADDR_T0_LOW, 8'h06);
        rd(`TTCU_ADDR_T1_LOW, 8'h06);
        $display("gating done");
        ld(8'h33, 8'hFE, 8'hFF, 8'h00, 8'h00);
        run(8'h50, 3, f);
        `CHK(f, 2'b11)
        rd(`TTCU_ADDR_T0_LOW, 8'h01);
        rd(`TTCU_ADDR_T0_HIGH, 8'h02);
        rd(`TTCU_ADDR_T1_LOW, 8'h00);
        $display("split done");
        repeat (2) @(negedge clk);
        test_done();
    end
endmodule
bind ttcu_timer_unit ttcu_timer_unit_checker u_chk (.clk, .reset, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .sfr_bit_wr, .sfr_bit_addr, .sfr_bit_wdata, .unit0_vector_ack,
    .unit1_vector_ack, .unit0_overflow_flag, .unit1_overflow_flag);
